// [verilog/ssn_notifier.sv]
// Local design decisions: the register offsets and the strobed register port.
module ssn_notifier (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Line state from the UART
   input wire logic overrun_evt_i,
   input wire logic parity_evt_i,
   input wire logic framing_evt_i,
   input wire logic ring_i,
   input wire logic break_i,
   input wire logic dsr_i,
   input wire logic cd_i,
   // General pins
   input wire logic [5:0] gen_pin_i,
   input wire logic [5:0] gen_pin_is_out_i,
   // Byte stream toward the interrupt endpoint
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   output logic irq_o
);
   // ==========================================================
   // Declarations
   ssn_pkg::ssn_state_t state_ff;
   logic [7:0] pin_en_ff;
   logic vendor_en_ff;
   logic [5:0] chg_mask_ff;
   logic [5:0] pin_prev_ff;
   logic ovr_pend_ff;
   logic par_pend_ff;
   logic frm_pend_ff;
   logic [3:0] line_prev_ff;
   logic req_pend_ff;
   logic [15:0] pkt_word_ff;
   logic pkt_vendor_ff;
   logic [3:0] idx_ff;
   logic [2:0] irq_sts_ff;
   logic [2:0] irq_en_ff;
   logic [7:0] tx_data_ff;
   logic tx_valid_ff;
   logic tx_last_ff;
   logic [15:0] rdata_ff;
   logic irq_ff;
   logic [15:0] cur_word;
   logic [5:0] pin_chg;
   logic line_chg;
   logic start;
   logic accept;
   logic sw_send;
   logic [2:0] irq_set;
   logic [2:0] nxt_irq_sts;
   ssn_pkg::ssn_line_t cur_line;

   // Byte at a given offset, multi-byte fields low byte first
   function automatic logic [7:0] byte_at(input logic [3:0] idx, input logic [15:0] w);
      case (idx)
         4'h0: byte_at = ssn_pkg::SSN_REQ_TYPE;
         4'h1: byte_at = ssn_pkg::SSN_NOTIF_CODE;
         4'h2: byte_at = ssn_pkg::SSN_VALUE[7:0];
         4'h3: byte_at = ssn_pkg::SSN_VALUE[15:8];
         4'h4: byte_at = ssn_pkg::SSN_INDEX[7:0];
         4'h5: byte_at = ssn_pkg::SSN_INDEX[15:8];
         4'h6: byte_at = ssn_pkg::SSN_LENGTH[7:0];
         4'h7: byte_at = ssn_pkg::SSN_LENGTH[15:8];
         4'h8: byte_at = w[7:0];
         4'h9: byte_at = w[15:8];
         default: byte_at = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // Event detection and status word
   assign cur_line = '{overrun: ovr_pend_ff, parity: par_pend_ff, framing: frm_pend_ff,
      ring: ring_i, brk: break_i, dsr: dsr_i, cd: cd_i};
   assign pin_chg = (gen_pin_i ^ pin_prev_ff) & ~gen_pin_is_out_i & chg_mask_ff;
   assign line_chg = (line_prev_ff != {ring_i, break_i, dsr_i, cd_i});
   assign start = (state_ff == ssn_pkg::SSN_IDLE) && req_pend_ff;
   assign accept = tx_valid_ff && tx_ready_i;
   assign sw_send = reg_wr_i && (reg_addr_i == ssn_pkg::SSN_REG_CTRL)
      && reg_wdata_i[ssn_pkg::SSN_CTRL_SEND];

   ssn_word_builder #(
      .PIN_CNT(ssn_pkg::SSN_PIN_CNT)
   ) u_word (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .line_i(cur_line),
      .pins_i(gen_pin_i),
      .pin_en_i(pin_en_ff),
      .vendor_en_i(vendor_en_ff),
      .word_o(cur_word)
   );

   // Previous pin and line levels
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pin_prev_ff <= 6'h00;
         line_prev_ff <= 4'h0;
      end else begin
         pin_prev_ff <= gen_pin_i;
         line_prev_ff <= {ring_i, break_i, dsr_i, cd_i};
      end
   end

   // Sticky receive errors until carried in a packet, new event wins
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ovr_pend_ff <= 1'b0;
         par_pend_ff <= 1'b0;
         frm_pend_ff <= 1'b0;
      end else begin
         ovr_pend_ff <= overrun_evt_i || (ovr_pend_ff && !start);
         par_pend_ff <= parity_evt_i || (par_pend_ff && !start);
         frm_pend_ff <= framing_evt_i || (frm_pend_ff && !start);
      end
   end

   // Packet request, new cause wins over the start
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         req_pend_ff <= 1'b0;
      end else begin
         req_pend_ff <= (|pin_chg) || line_chg || overrun_evt_i || parity_evt_i
            || framing_evt_i || sw_send || (req_pend_ff && !start);
      end
   end

   // ==========================================================
   // Packet sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= ssn_pkg::SSN_IDLE;
         idx_ff <= 4'h0;
         pkt_word_ff <= 16'h0000;
         pkt_vendor_ff <= 1'b0;
         tx_data_ff <= 8'h00;
         tx_valid_ff <= 1'b0;
         tx_last_ff <= 1'b0;
      end else begin
         case (state_ff)
            ssn_pkg::SSN_IDLE: begin
               if (start) begin
                  pkt_word_ff <= cur_word;
                  pkt_vendor_ff <= vendor_en_ff;
                  idx_ff <= 4'h0;
                  tx_data_ff <= byte_at(4'h0, cur_word);
                  tx_valid_ff <= 1'b1;
                  tx_last_ff <= 1'b0;
                  state_ff <= ssn_pkg::SSN_SEND;
               end
            end
            ssn_pkg::SSN_SEND: begin
               if (accept) begin
                  if (idx_ff == ssn_pkg::SSN_LAST_BYTE) begin
                     tx_valid_ff <= 1'b0;
                     tx_last_ff <= 1'b0;
                     state_ff <= ssn_pkg::SSN_DONE;
                  end else begin
                     idx_ff <= idx_ff + 4'h1;
                     tx_data_ff <= byte_at(idx_ff + 4'h1, pkt_word_ff);
                     tx_last_ff <= (idx_ff + 4'h1) == ssn_pkg::SSN_LAST_BYTE;
                  end
               end
            end
            ssn_pkg::SSN_DONE: begin
               state_ff <= ssn_pkg::SSN_IDLE;
            end
            default: begin
               state_ff <= ssn_pkg::SSN_IDLE;
               tx_valid_ff <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Register writes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pin_en_ff <= ssn_pkg::SSN_PIN_EN_RST;
         vendor_en_ff <= 1'b0;
         chg_mask_ff <= ssn_pkg::SSN_CHG_MASK_RST;
         irq_en_ff <= ssn_pkg::SSN_IRQ_EN_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ssn_pkg::SSN_REG_PIN_EN: begin
               pin_en_ff <= reg_wdata_i[7:0] & ssn_pkg::SSN_PIN_EN_WMASK;
            end
            ssn_pkg::SSN_REG_CTRL: begin
               vendor_en_ff <= reg_wdata_i[ssn_pkg::SSN_CTRL_VENDOR];
            end
            ssn_pkg::SSN_REG_CHG_MASK: begin
               chg_mask_ff <= reg_wdata_i[5:0];
            end
            ssn_pkg::SSN_REG_IRQ_EN: begin
               irq_en_ff <= reg_wdata_i[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Interrupt status, set wins over clear
   assign irq_set = {overrun_evt_i || parity_evt_i || framing_evt_i, |pin_chg,
      state_ff == ssn_pkg::SSN_DONE};
   always_comb begin
      nxt_irq_sts = irq_sts_ff;
      if (reg_wr_i && (reg_addr_i == ssn_pkg::SSN_REG_IRQ_CLR)) begin
         nxt_irq_sts = nxt_irq_sts & ~reg_wdata_i[2:0];
      end
      nxt_irq_sts = nxt_irq_sts | irq_set;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_sts_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         irq_sts_ff <= nxt_irq_sts;
         irq_ff <= |(nxt_irq_sts & irq_en_ff);
      end
   end

   // Register reads, data only in the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ssn_pkg::SSN_REG_PIN_EN: rdata_ff <= {8'h00, pin_en_ff};
            ssn_pkg::SSN_REG_CTRL: rdata_ff <= {15'h0000, vendor_en_ff};
            ssn_pkg::SSN_REG_CHG_MASK: rdata_ff <= {10'h000, chg_mask_ff};
            ssn_pkg::SSN_REG_LAST_WORD: rdata_ff <= pkt_word_ff;
            ssn_pkg::SSN_REG_IRQ_STS: rdata_ff <= {13'h0000, irq_sts_ff};
            ssn_pkg::SSN_REG_IRQ_EN: rdata_ff <= {13'h0000, irq_en_ff};
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   // Outputs
   assign reg_rdata_o = rdata_ff;
   assign tx_data_o = tx_data_ff;
   assign tx_valid_o = tx_valid_ff;
   assign tx_last_o = tx_last_ff;
   assign irq_o = irq_ff;

   // ==========================================================
   // Checks on the packet stream and the register read data
   a_hdr_type: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && idx_ff == 4'h0) |-> (tx_data_o == 8'hA1))
      else $error("request type byte wrong");
   a_hdr_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && tx_ready_i && idx_ff == 4'h0) |=> (tx_data_o == 8'h20))
      else $error("notification code byte wrong");
   a_zero_fields: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && idx_ff >= 4'h2 && idx_ff <= 4'h5) |-> (tx_data_o == 8'h00))
      else $error("value or index field not zero");
   a_len_field: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && idx_ff == 4'h6) |-> (tx_data_o == 8'h02))
      else $error("length low byte not 2");
   a_word_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && tx_ready_i && idx_ff == 4'h8) |=> (tx_data_o == pkt_word_ff[15:8])
      && tx_last_o)
      else $error("status word not sent low byte first");
   a_std_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && idx_ff == 4'h9 && !pkt_vendor_ff) |-> (tx_data_o == 8'h00))
      else $error("standard map high byte not zero");
   a_vendor_rsvd: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (tx_valid_o && idx_ff == 4'h9) |-> (tx_data_o[7] == 1'b0 && tx_data_o[2] == 1'b0))
      else $error("reserved vendor bits set");
   a_overrun_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (overrun_evt_i && state_ff == ssn_pkg::SSN_IDLE && !start) |=> (start && cur_word[6]))
      else $error("overrun not carried into packet");
   a_err_cleared: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (start && !overrun_evt_i && !parity_evt_i && !framing_evt_i) |=> (cur_word[6:4] == 3'h0))
      else $error("error bits not cleared after packet start");
   a_last_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      tx_valid_o |-> (tx_last_o == (idx_ff == ssn_pkg::SSN_LAST_BYTE)))
      else $error("last flag not on the final byte");
   a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !reg_rd_i |=> (reg_rdata_o == 16'h0000))
      else $error("read data shown without a read");
   a_pin_trigger: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (|pin_chg && state_ff == ssn_pkg::SSN_IDLE && !req_pend_ff) |=> start)
      else $error("masked pin change did not start packet");
   a_ring_live: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      start |-> (cur_word[3] == ring_i && cur_word[2] == break_i))
      else $error("ring or break not live state");
   a_pin5_word: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (start && vendor_en_ff && pin_en_ff[6]) |-> (cur_word[14] == gen_pin_i[5]))
      else $error("pin 5 not in bit 14");
   a_line_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      start |-> (cur_word[1:0] == {dsr_i, cd_i} && cur_word[5] == par_pend_ff))
      else $error("line bits misplaced");
endmodule // ssn_notifier

// [verilog/ssn_pkg.sv]
package ssn_pkg;
   // ==========================================================
   // Register map, word index on the register port
   localparam logic [3:0] SSN_REG_PIN_EN = 4'h0;
   localparam logic [3:0] SSN_REG_CTRL = 4'h1;
   localparam logic [3:0] SSN_REG_CHG_MASK = 4'h2;
   localparam logic [3:0] SSN_REG_LAST_WORD = 4'h3;
   localparam logic [3:0] SSN_REG_IRQ_STS = 4'h4;
   localparam logic [3:0] SSN_REG_IRQ_CLR = 4'h5;
   localparam logic [3:0] SSN_REG_IRQ_EN = 4'h6;

   // ==========================================================
   // Field positions and reset values
   localparam int SSN_CTRL_VENDOR = 0;
   localparam int SSN_CTRL_SEND = 1;
   localparam logic [7:0] SSN_PIN_EN_WMASK = 8'h7B;
   localparam logic [7:0] SSN_PIN_EN_RST = 8'h00;
   localparam logic [5:0] SSN_CHG_MASK_RST = 6'h00;
   localparam logic [2:0] SSN_IRQ_EN_RST = 3'h0;
   localparam int SSN_IRQ_SENT = 0;
   localparam int SSN_IRQ_PIN = 1;
   localparam int SSN_IRQ_ERR = 2;

   // ==========================================================
   // Notification packet contents
   localparam logic [7:0] SSN_REQ_TYPE = 8'hA1;
   localparam logic [7:0] SSN_NOTIF_CODE = 8'h20;
   localparam logic [15:0] SSN_VALUE = 16'h0000;
   localparam logic [15:0] SSN_INDEX = 16'h0000;
   localparam logic [15:0] SSN_LENGTH = 16'h0002;
   localparam logic [3:0] SSN_LAST_BYTE = 4'h9;
   localparam int SSN_PIN_CNT = 6;
   // Status-word bit and enable bit for general pins 0..5
   localparam int SSN_PIN_WBIT [SSN_PIN_CNT] = '{11, 8, 9, 12, 13, 14};
   localparam int SSN_PIN_EBIT [SSN_PIN_CNT] = '{3, 0, 1, 4, 5, 6};

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SSN_IDLE = 2'b00,
      SSN_SEND = 2'b01,
      SSN_DONE = 2'b11
   } ssn_state_t;

   typedef struct packed {
      logic overrun;
      logic parity;
      logic framing;
      logic ring;
      logic brk;
      logic dsr;
      logic cd;
   } ssn_line_t;
endpackage

// [verilog/ssn_word_builder.sv]
module ssn_word_builder #(
   parameter int PIN_CNT = 6
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire ssn_pkg::ssn_line_t line_i,
   input wire logic [PIN_CNT-1:0] pins_i,
   input wire logic [7:0] pin_en_i,
   input wire logic vendor_en_i,
   output logic [15:0] word_o
);
   // ==========================================================
   // Elaboration check
   if (PIN_CNT != ssn_pkg::SSN_PIN_CNT) begin : g_bad_cnt
      $error("pin count must match the vendor bit map");
   end

   // ==========================================================
   // Status word assembly
   always_comb begin
      word_o = 16'h0000;
      word_o[6:0] = line_i;
      if (vendor_en_i) begin
         for (int i = 0; i < PIN_CNT; i++) begin
            if (pin_en_i[ssn_pkg::SSN_PIN_EBIT[i]]) begin
               word_o[ssn_pkg::SSN_PIN_WBIT[i]] = pins_i[i];
            end
         end
      end
   end

   // Checks on the word mapping
   a_pin3_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!pin_en_i[4] || !vendor_en_i) |-> !word_o[12])
      else $error("pin 3 shown while its enable is clear");
   a_pin0_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (vendor_en_i && pin_en_i[3]) |-> (word_o[11] == pins_i[0]))
      else $error("pin 0 not reported in bit 11");
   a_live_lines: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (word_o[1] == line_i.dsr) && (word_o[0] == line_i.cd) && (word_o[3] == line_i.ring))
      else $error("modem line bits do not follow inputs");
endmodule // ssn_word_builder

// [tb/ssn_host_model.sv]
module ssn_host_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] data_i,
   input wire logic valid_i,
   input wire logic last_i,
   input wire logic stall_i,
   output logic ready_o,
   output logic [79:0] pkt_o,
   output logic [4:0] len_o,
   output int cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [79:0] work_ff;
   logic [4:0] idx_ff;
   // ==========================================
   // Endpoint sink
   // Ready is withheld at random while stalling
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= stall_i ? 1'($urandom_range(1)) : 1'b1;
      end
   end
   // Accepted bytes gathered, packet closed by the last flag
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         idx_ff <= 5'h00;
         cnt_o <= 0;
         len_o <= 5'h00;
      end else if (valid_i && ready_o) begin
         work_ff[8*idx_ff +: 8] <= data_i;
         idx_ff <= idx_ff + 5'h01;
         if (last_i) begin
            pkt_o <= work_ff;
            pkt_o[8*idx_ff +: 8] <= data_i;
            len_o <= idx_ff + 5'h01;
            cnt_o <= cnt_o + 1;
            idx_ff <= 5'h00;
         end
      end
   end
endmodule // ssn_host_model

// [tb/ssn_notifier_bench.sv]
module ssn_notifier_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   logic overrun_evt_i, parity_evt_i, framing_evt_i;
   logic ring_i, break_i, dsr_i, cd_i;
   logic [5:0] gen_pin_i, gen_pin_is_out_i;
   logic [7:0] tx_data_o;
   logic tx_valid_o, tx_last_o, tx_ready_i, irq_o, stall, ven;
   logic [79:0] pkt;
   logic [4:0] pkt_len;
   logic [7:0] en;
   logic [15:0] rdat, w;
   int pkt_cnt, cnt;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int wbit [6] = '{11, 8, 9, 12, 13, 14};
   int ebit [6] = '{3, 0, 1, 4, 5, 6};
   logic [3:0] ra [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hF};

   ssn_notifier dut_u (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .overrun_evt_i, .parity_evt_i, .framing_evt_i, .ring_i, .break_i, .dsr_i,
      .cd_i, .gen_pin_i, .gen_pin_is_out_i, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
      .irq_o);
   ssn_host_model host_u (.sys_clk_i, .rst_n_i, .data_i(tx_data_o), .valid_i(tx_valid_o),
      .last_i(tx_last_o), .stall_i(stall), .ready_o(tx_ready_i), .pkt_o(pkt), .len_o(pkt_len),
      .cnt_o(pkt_cnt));

   // ==========================================
   // Clock and hang guard
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // Cycle ceiling cuts a hang short
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         wrap_up();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // Waits until the stream has been quiet for 16 cycles
   task automatic settle();
      int q;
      q = 0;
      while (q < 16) begin
         @(posedge sys_clk_i);
         #1 q = tx_valid_o ? 0 : q + 1;
      end
      // Hand back on a clock edge so the next stimulus lands there
      @(posedge sys_clk_i);
   endtask
   task automatic get_pkt(input int c, output logic [15:0] word);
      logic [7:0] hdr [8];
      int k;
      hdr = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
      k = 0;
      while (pkt_cnt == c && k < 200) begin
         @(posedge sys_clk_i);
         k++;
      end
      #1 check(16'(pkt_cnt - c), 16'h0001);
      check(16'(pkt_len), 16'h000A);
      for (k = 0; k < 8; k++) begin
         check(16'(pkt[8*k +: 8]), 16'(hdr[k]));
      end
      word = pkt[79:64];
   endtask
   task automatic send();
      settle();
      cnt = pkt_cnt;
      wr(ssn_pkg::SSN_REG_CTRL, {14'h0000, 1'b1, ven});
      get_pkt(cnt, w);
   endtask
   // Status word expected from live levels and the given error bits
   function automatic logic [15:0] exp_word(input logic [2:0] err);
      logic [15:0] x;
      x = {9'h000, err, ring_i, break_i, dsr_i, cd_i};
      for (int k = 0; k < 6; k++) begin
         if (ven && en[ebit[k]]) begin
            x[wbit[k]] = gen_pin_i[k];
         end
      end
      return x;
   endfunction
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
      {overrun_evt_i, parity_evt_i, framing_evt_i, ring_i, break_i, dsr_i, cd_i} = '0;
      gen_pin_i = 6'h00;
      gen_pin_is_out_i = 6'h3F;
      rst_n_i = 1'b0;
      stall = 1'b0;
      ven = 1'b0;
      en = 8'h00;
      void'($urandom(32'h281E));
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      // Reset values, unmapped address reads zero
      foreach (ra[i]) begin
         rd(ra[i], rdat);
         check(rdat, 16'h0000);
      end
      wr(ssn_pkg::SSN_REG_PIN_EN, 16'h007F);
      rd(ssn_pkg::SSN_REG_PIN_EN, rdat);
      check(rdat, 16'h007B);
      // Mapping, enables and live levels, corners first then random
      for (int i = 0; i < 12; i++) begin
         ven = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom_range(1));
         en = (i < 2) ? 8'h7F : 8'($urandom_range(127));
         stall <= 1'($urandom_range(1));
         wr(ssn_pkg::SSN_REG_PIN_EN, {8'h00, en});
         wr(ssn_pkg::SSN_REG_CTRL, {15'h0000, ven});
         @(posedge sys_clk_i);
         gen_pin_i <= (i < 2) ? 6'h3F : 6'($urandom_range(63));
         {ring_i, break_i, dsr_i, cd_i} <= 4'($urandom_range(15));
         send();
         check(w, exp_word(3'b000));
         rd(ssn_pkg::SSN_REG_LAST_WORD, rdat);
         check(rdat, exp_word(3'b000));
      end
      // Each error event reported once, then cleared
      for (int k = 0; k < 3; k++) begin
         settle();
         cnt = pkt_cnt;
         {overrun_evt_i, parity_evt_i, framing_evt_i} <= 3'(1 << k);
         @(posedge sys_clk_i);
         {overrun_evt_i, parity_evt_i, framing_evt_i} <= 3'b000;
         get_pkt(cnt, w);
         check(w, exp_word(3'(1 << k)));
         send();
         check(w, exp_word(3'b000));
      end
      // Interrupt raised, cleared, then masked
      wr(ssn_pkg::SSN_REG_IRQ_CLR, 16'h0007);
      wr(ssn_pkg::SSN_REG_IRQ_EN, 16'h0001);
      send();
      repeat (3) @(posedge sys_clk_i);
      #1 check(16'(irq_o), 16'h0001);
      rd(ssn_pkg::SSN_REG_IRQ_STS, rdat);
      check(rdat, 16'h0001);
      wr(ssn_pkg::SSN_REG_IRQ_CLR, 16'h0001);
      repeat (2) @(posedge sys_clk_i);
      #1 check(16'(irq_o), 16'h0000);
      wr(ssn_pkg::SSN_REG_IRQ_EN, 16'h0000);
      send();
      repeat (3) @(posedge sys_clk_i);
      #1 check(16'(irq_o), 16'h0000);
      // Pin change triggers only when masked in and an input
      wr(ssn_pkg::SSN_REG_CHG_MASK, 16'h0001);
      gen_pin_is_out_i <= 6'h00;
      settle();
      cnt = pkt_cnt;
      gen_pin_i <= gen_pin_i ^ 6'h01;
      get_pkt(cnt, w);
      check(w, exp_word(3'b000));
      rd(ssn_pkg::SSN_REG_IRQ_STS, rdat);
      check(rdat, 16'h0003);
      @(posedge sys_clk_i);
      cnt = pkt_cnt;
      gen_pin_i <= gen_pin_i ^ 6'h02;
      settle();
      check(16'(pkt_cnt - cnt), 16'h0000);
      gen_pin_is_out_i <= 6'h01;
      settle();
      cnt = pkt_cnt;
      gen_pin_i <= gen_pin_i ^ 6'h01;
      settle();
      check(16'(pkt_cnt - cnt), 16'h0000);
      wrap_up();
   end
endmodule // ssn_notifier_bench
